//--- verilog/mbim_pkg.sv
// Constants and types shared by the input module setup register bank
package mbim_pkg;

  // Register numbers as the serial master addresses them
  localparam logic [15:0] NODE_ADDR_REG = 16'h9C41;
  localparam logic [15:0] SERIAL_SETUP_REG = 16'h9C42;
  localparam logic [15:0] DELAYS_REG = 16'h9C43;
  localparam logic [15:0] FW_VERSION_REG = 16'h9C61;
  localparam logic [15:0] CONV_STATUS_REG = 16'h9C70;

  // Values after reset
  localparam logic [15:0] NODE_ADDR_RST = 16'h0001;
  localparam logic [15:0] SERIAL_SETUP_RST = 16'h0035;
  localparam logic [15:0] DELAYS_RST = 16'h0003;
  localparam logic [15:0] CONV_STATUS_RST = 16'h0000;

  // Legal write ranges
  localparam logic [15:0] NODE_ADDR_MIN = 16'h0001;
  localparam logic [15:0] NODE_ADDR_MAX = 16'h00DF;
  localparam logic [7:0] REPLY_DLY_MAX = 8'h3F;
  localparam logic [7:0] QUERY_DLY_MAX = 8'h30;

  // Field positions of the delay and conversion status words
  localparam int REPLY_DLY_LSB = 0;
  localparam int QUERY_DLY_LSB = 8;
  localparam int CONV_CNT_LSB = 0;
  localparam int LAST_CHAN_LSB = 8;

  // Exception codes returned on a refused access
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [7:0] EXC_NAK = 8'h07;

  // Timing
  localparam longint CLK_HZ = 250_000_000;
  localparam longint MS_PER_S = 1000;
  localparam longint CONV_PER_SEC = 25;
  localparam longint CHAR_BITS = 11;
  localparam longint DEFAULT_BAUD = 9600;
  localparam longint SILENCE_CHARS_X10 = 35;
  localparam int MS_CYCLES = int'(CLK_HZ / MS_PER_S);
  localparam int CONV_PERIOD_CYCLES = int'(CLK_HZ / CONV_PER_SEC);
  localparam int SILENCE_CYCLES = int'((CLK_HZ * CHAR_BITS * SILENCE_CHARS_X10
      + DEFAULT_BAUD * 10 - 1) / (DEFAULT_BAUD * 10));
  localparam int CNT_W = 24;
  localparam int NUM_CHAN = 7;

  // Frame timing states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RX = 4'b0010,
    ST_QUERY = 4'b0100,
    ST_REPLY = 4'b1000
  } mbim_state_t;

endpackage : mbim_pkg

//--- verilog/mbim_setup_regs.sv
// Setup and status register bank of the seven channel analog input module
// Functional notes
// - node address writable, 1 to DF, resets 0x0001
// - serial setup writable, resets to 0x0035
// - low delay byte: reply delay, max 63ms
// - high delay byte: query delay, max 48ms
// - end of frame waits silence plus delay
// - firmware version read-only, writes have no effect
// - conversion counter increments, wraps FF to zero
// - bits 8-10 hold last converted channel
// - conversion status clears to zero on reset
// - setup writes refused with 07 unless enabled
// - 25 conversions per second shared by enabled channels
module mbim_setup_regs
  import mbim_pkg::*;
#(
  parameter logic [15:0] FW_VERSION = 16'h0100, // Arbitrary value
  parameter int MS_CYC = MS_CYCLES,
  parameter int CONV_PERIOD = CONV_PERIOD_CYCLES,
  parameter int SILENCE_CYC = SILENCE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register access from the protocol engine
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  output logic regAck,
  output logic [15:0] regRdData,
  output logic [7:0] regExc,
  input wire logic nvWriteEnable,
  // Serial receive activity and frame timing
  input wire logic rxActivity,
  output logic frameEnd,
  output logic replyGo,
  // Converter scheduling
  input wire logic [NUM_CHAN-1:0] chanEnable,
  output logic convStart,
  output logic [2:0] convSel,
  input wire logic convDone,
  input wire logic [2:0] convDoneChan,
  // Setup values to the rest of the module
  output logic [15:0] nodeAddr,
  output logic [15:0] serialSetup
);

  logic [15:0] nodeAddr_q, nodeAddr_d;
  logic [15:0] serialSetup_q, serialSetup_d;
  logic [15:0] delays_q, delays_d;
  logic [7:0] convCnt_q, convCnt_d;
  logic [2:0] lastChan_q, lastChan_d;
  logic regAck_q, regAck_d;
  logic [15:0] regRdData_q, regRdData_d;
  logic [7:0] regExc_q, regExc_d;

  logic [7:0] replyDly, queryDly;
  assign replyDly = delays_q[REPLY_DLY_LSB +: 8];
  assign queryDly = delays_q[QUERY_DLY_LSB +: 8];

  // Register access: answer one cycle after the request
  always_comb begin
    nodeAddr_d = nodeAddr_q;
    serialSetup_d = serialSetup_q;
    delays_d = delays_q;
    regAck_d = regReq;
    regRdData_d = 16'h0000;
    regExc_d = EXC_NONE;
    if (regReq && !regWrite) begin
      unique case (regAddr)
        NODE_ADDR_REG: regRdData_d = nodeAddr_q;
        SERIAL_SETUP_REG: regRdData_d = serialSetup_q;
        DELAYS_REG: regRdData_d = delays_q;
        FW_VERSION_REG: regRdData_d = FW_VERSION;
        CONV_STATUS_REG: begin
          regRdData_d = 16'h0000;
          regRdData_d[CONV_CNT_LSB +: 8] = convCnt_q;
          regRdData_d[LAST_CHAN_LSB +: 3] = lastChan_q;
        end
        default: regExc_d = EXC_ILLEGAL_ADDR;
      endcase
    end else if (regReq && regWrite) begin
      unique case (regAddr)
        NODE_ADDR_REG, SERIAL_SETUP_REG, DELAYS_REG: begin
          if (!nvWriteEnable) begin
            regExc_d = EXC_NAK;
          end else if (regAddr == NODE_ADDR_REG) begin
            if (regWrData < NODE_ADDR_MIN || regWrData > NODE_ADDR_MAX) begin
              regExc_d = EXC_ILLEGAL_VALUE;
            end else begin
              nodeAddr_d = regWrData;
            end
          end else if (regAddr == SERIAL_SETUP_REG) begin
            serialSetup_d = regWrData;
          end else if (regWrData[REPLY_DLY_LSB +: 8] > REPLY_DLY_MAX
                       || regWrData[QUERY_DLY_LSB +: 8] > QUERY_DLY_MAX) begin
            regExc_d = EXC_ILLEGAL_VALUE;
          end else begin
            delays_d = regWrData;
          end
        end
        // Read-only words refuse writes and keep their content
        FW_VERSION_REG, CONV_STATUS_REG: regExc_d = EXC_ILLEGAL_ADDR;
        default: regExc_d = EXC_ILLEGAL_ADDR;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      nodeAddr_q <= NODE_ADDR_RST;
      serialSetup_q <= SERIAL_SETUP_RST;
      delays_q <= DELAYS_RST;
      regAck_q <= 1'b0;
      regRdData_q <= 16'h0000;
      regExc_q <= EXC_NONE;
    end else begin
      nodeAddr_q <= nodeAddr_d;
      serialSetup_q <= serialSetup_d;
      delays_q <= delays_d;
      regAck_q <= regAck_d;
      regRdData_q <= regRdData_d;
      regExc_q <= regExc_d;
    end
  end

  // Conversion status
  always_comb begin
    convCnt_d = convCnt_q;
    lastChan_d = lastChan_q;
    if (convDone) begin
      convCnt_d = convCnt_q + 8'h01;
      lastChan_d = convDoneChan;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      convCnt_q <= CONV_STATUS_RST[CONV_CNT_LSB +: 8];
      lastChan_q <= CONV_STATUS_RST[LAST_CHAN_LSB +: 3];
    end else begin
      convCnt_q <= convCnt_d;
      lastChan_q <= lastChan_d;
    end
  end

  // Conversion pacing: one start per period, round robin over enabled channels
  logic [CNT_W-1:0] convTmr_q, convTmr_d;
  logic convStart_q, convStart_d;
  logic [2:0] convSel_q, convSel_d;

  always_comb begin
    logic found;
    logic [2:0] idx;
    found = 1'b0;
    idx = 3'h0;
    convTmr_d = convTmr_q + 1'b1;
    convStart_d = 1'b0;
    convSel_d = convSel_q;
    if (convTmr_q == CNT_W'(CONV_PERIOD - 1)) begin
      convTmr_d = '0;
      // Disabled channels are skipped, so the others are sampled more often
      for (int k = 1; k <= NUM_CHAN; k++) begin
        idx = 3'((int'(convSel_q) + k) % NUM_CHAN);
        if (!found && chanEnable[idx]) begin
          found = 1'b1;
          convSel_d = idx;
        end
      end
      convStart_d = found;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      convTmr_q <= '0;
      convStart_q <= 1'b0;
      convSel_q <= 3'(NUM_CHAN - 1);
    end else begin
      convTmr_q <= convTmr_d;
      convStart_q <= convStart_d;
      convSel_q <= convSel_d;
    end
  end

  // Frame timing: silence, then query delay, then reply delay
  mbim_state_t state_q, state_d;
  logic [CNT_W-1:0] tmr_q, tmr_d;
  logic [7:0] msCnt_q, msCnt_d;
  logic frameEnd_q, frameEnd_d;
  logic replyGo_q, replyGo_d;
  logic msTick;

  assign msTick = (tmr_q == CNT_W'(MS_CYC - 1));

  always_comb begin
    state_d = state_q;
    tmr_d = tmr_q + 1'b1;
    msCnt_d = msCnt_q;
    frameEnd_d = 1'b0;
    replyGo_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        tmr_d = '0;
        if (rxActivity) begin
          state_d = ST_RX;
        end
      end
      ST_RX: begin
        if (rxActivity) begin
          tmr_d = '0;
        end else if (tmr_q == CNT_W'(SILENCE_CYC - 1)) begin
          tmr_d = '0;
          msCnt_d = 8'h00;
          state_d = ST_QUERY;
        end
      end
      ST_QUERY: begin
        // A late character from a slow host keeps the frame open
        if (rxActivity) begin
          tmr_d = '0;
          state_d = ST_RX;
        end else if (msCnt_q >= queryDly) begin
          tmr_d = '0;
          msCnt_d = 8'h00;
          frameEnd_d = 1'b1;
          state_d = ST_REPLY;
        end else if (msTick) begin
          tmr_d = '0;
          msCnt_d = msCnt_q + 8'h01;
        end
      end
      ST_REPLY: begin
        // Gives the host driver time to release the line
        if (msCnt_q >= replyDly) begin
          tmr_d = '0;
          replyGo_d = 1'b1;
          state_d = ST_IDLE;
        end else if (msTick) begin
          tmr_d = '0;
          msCnt_d = msCnt_q + 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      tmr_q <= '0;
      msCnt_q <= 8'h00;
      frameEnd_q <= 1'b0;
      replyGo_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      msCnt_q <= msCnt_d;
      frameEnd_q <= frameEnd_d;
      replyGo_q <= replyGo_d;
    end
  end

  assign regAck = regAck_q;
  assign regRdData = regRdData_q;
  assign regExc = regExc_q;
  assign frameEnd = frameEnd_q;
  assign replyGo = replyGo_q;
  assign convStart = convStart_q;
  assign convSel = convSel_q;
  assign nodeAddr = nodeAddr_q;
  assign serialSetup = serialSetup_q;

endmodule : mbim_setup_regs

//--- verif/mbim_setup_regs_sva.sv
// Port checker for the setup register bank
module mbim_setup_regs_chk
  import mbim_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register access
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic nvWriteEnable,
  input wire logic regAck,
  input wire logic [15:0] regRdData,
  input wire logic [7:0] regExc,
  // Frame timing and conversion
  input wire logic frameEnd,
  input wire logic replyGo,
  input wire logic convDone,
  input wire logic [2:0] convDoneChan,
  // Setup values
  input wire logic [15:0] nodeAddr,
  input wire logic [15:0] serialSetup
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic setW;
  logic okW;
  assign setW = regReq && regWrite && regAddr >= NODE_ADDR_REG && regAddr <= DELAYS_REG;
  assign okW = setW && nvWriteEnable;
  rst_vals_a: assert property ($fell(sys_rst) |->
    nodeAddr == NODE_ADDR_RST && serialSetup == SERIAL_SETUP_RST) else $error("bad reset");
  ack_time_a: assert property (regReq |=> regAck) else $error("no answer");
  nak_a: assert property (setW && !nvWriteEnable |=> regExc == EXC_NAK
    && $stable(nodeAddr) && $stable(serialSetup)) else $error("no refusal");
  ro_write_a: assert property (regReq && regWrite && (regAddr == FW_VERSION_REG
    || regAddr == CONV_STATUS_REG) |=> regExc == EXC_ILLEGAL_ADDR) else $error("ro write");
  addr_range_a: assert property (okW && regAddr == NODE_ADDR_REG
    && (regWrData < NODE_ADDR_MIN || regWrData > NODE_ADDR_MAX)
    |=> regExc == EXC_ILLEGAL_VALUE && $stable(nodeAddr)) else $error("range");
  addr_write_a: assert property (okW && regAddr == NODE_ADDR_REG
    && regWrData >= NODE_ADDR_MIN && regWrData <= NODE_ADDR_MAX
    |=> nodeAddr == $past(regWrData)) else $error("node write");
  setup_write_a: assert property (okW && regAddr == SERIAL_SETUP_REG
    |=> serialSetup == $past(regWrData)) else $error("setup write");
  last_chan_a: assert property (convDone ##1 (regReq && !regWrite
    && regAddr == CONV_STATUS_REG && !convDone)
    |=> regRdData[10:8] == $past(convDoneChan, 2) && regRdData[15:11] == 5'h00)
    else $error("last channel");
  // Set by the end of a frame, spent by its reply; a zero reply delay is legal
  logic framePend_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      framePend_q <= 1'b0;
    end else if (frameEnd) begin
      framePend_q <= 1'b1;
    end else if (replyGo) begin
      framePend_q <= 1'b0;
    end
  end
  frame_order_a: assert property (replyGo |-> !frameEnd && framePend_q)
    else $error("order");
  cover property (setW && !nvWriteEnable);
  cover property (frameEnd);
  cover property (convDone && convDoneChan == 3'h6);
endmodule : mbim_setup_regs_chk

bind mbim_setup_regs mbim_setup_regs_chk u_chk (.*);

//--- verif/mbim_conv_model.sv
// Converter model answering each start after a short or long latency
module mbim_conv_model (
  // Clock
  input wire logic core_clk,
  // Converter handshake
  input wire logic convStart,
  input wire logic [2:0] convSel,
  input wire logic slow,
  output logic convDone,
  output logic [2:0] convDoneChan
);
  timeunit 1ns;
  timeprecision 1ps;
  int busy = 0;
  logic [2:0] chan = 3'h0;
  initial convDone = 1'b0;
  initial convDoneChan = 3'h7;
  // Channel lines toggle while idle so a stale index never looks valid
  always @(posedge core_clk) begin
    convDone <= 1'b0;
    convDoneChan <= ~convDoneChan;
    if (convStart) begin
      busy = slow ? 8 : 1;
      chan = convSel;
    end else if (busy > 0) begin
      busy--;
      if (busy == 0) begin
        convDone <= 1'b1;
        convDoneChan <= chan;
      end
    end
  end
endmodule : mbim_conv_model

//--- verif/test_mbim_setup_regs.sv
// Self-checking bench for the setup register bank
module test_mbim_setup_regs
  import mbim_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] FW = 16'h0A5C; // Arbitrary value
  localparam int MSC = 10;
  localparam int SIL = 30;
  logic core_clk = 0, sys_rst = 1, regReq = 0, regWrite = 0, nvWriteEnable = 0;
  logic rxActivity = 0, slow = 0, regAck, frameEnd, replyGo, convStart, convDone;
  logic [15:0] regAddr = 0, regWrData = 0, regRdData, nodeAddr, serialSetup, d;
  logic [6:0] chanEnable = 0, mask = 0;
  logic [7:0] regExc, cnt = 0;
  logic [2:0] convSel, convDoneChan, last = 0, prevSel = 3'h6;
  logic [23:0] expQ[$];
  int failures = 0, n_tests = 0, n;
  always #2 core_clk = ~core_clk;
  mbim_setup_regs #(.FW_VERSION(FW), .MS_CYC(MSC), .CONV_PERIOD(20), .SILENCE_CYC(SIL))
    u_dut (.*);
  mbim_conv_model u_conv (.*);
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] wd,
      input logic [15:0] rd, input logic [7:0] exc);
    @(posedge core_clk);
    #1;
    regReq = 1;
    regWrite = w;
    regAddr = a;
    regWrData = wd;
    expQ.push_back({rd, exc});
  endtask : acc
  // Requests are one-cycle pulses, so they drop after the first edge
  task automatic tick(input int k);
    @(posedge core_clk);
    #1;
    regReq = 0;
    rxActivity = 0;
    if (k > 1) begin
      repeat (k - 1) @(posedge core_clk);
      #1;
    end
  endtask : tick
  task automatic waitSig(input bit rep);
    n = 0;
    while ((rep ? replyGo : frameEnd) !== 1'b1) begin
      tick(1);
      n++;
      if (n > 200) begin
        failures++;
        summarize();
      end
    end
  endtask : waitSig
  // One received frame with a second character after the given gap
  task automatic frame(input int gap);
    @(posedge core_clk);
    #1;
    rxActivity = 1;
    tick(gap);
    rxActivity = 1;
    tick(1);
    waitSig(0);
    chk(24'(n >= SIL + 2 * MSC && n <= SIL + 2 * MSC + 6), 24'h1, "query wait");
    waitSig(1);
    chk(24'(n >= MSC && n <= MSC + 6), 24'h1, "reply wait");
  endtask : frame
  // Status is read right after each conversion, well inside one period
  task automatic poll();
    n = 0;
    while (convDone !== 1'b1) begin
      tick(1);
      n++;
      if (n > 200) begin
        failures++;
        summarize();
      end
    end
    acc(0, CONV_STATUS_REG, 0, {5'h00, convDoneChan, cnt + 8'h01}, EXC_NONE);
    tick(1);
  endtask : poll
  function automatic logic [2:0] nxt(input logic [2:0] c);
    logic [2:0] i;
    i = c;
    repeat (7) begin
      i = (i == 3'h6) ? 3'h0 : i + 3'h1;
      if (mask[i]) return i;
    end
    return c;
  endfunction : nxt
  // Answers pair with requests strictly in order
  always @(posedge core_clk) begin
    if (regAck === 1'b1) begin
      if (expQ.size() == 0) chk(24'h0, 24'h1, "spare answer");
      else chk({regRdData, regExc}, expQ.pop_front(), "answer");
    end
    if (convDone === 1'b1) begin
      cnt <= cnt + 8'h01;
      last <= convDoneChan;
    end
    if (convStart === 1'b1) begin
      chk({21'h0, convSel}, {21'h0, nxt(prevSel)}, "channel");
      prevSel <= convSel;
    end
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    failures++;
    summarize();
  end
  initial begin
    void'($urandom(32'h39937895));
    tick(10);
    sys_rst = 0;
    acc(0, NODE_ADDR_REG, 0, NODE_ADDR_RST, EXC_NONE);
    acc(0, SERIAL_SETUP_REG, 0, SERIAL_SETUP_RST, EXC_NONE);
    acc(0, DELAYS_REG, 0, DELAYS_RST, EXC_NONE);
    acc(0, FW_VERSION_REG, 0, FW, EXC_NONE);
    acc(0, CONV_STATUS_REG, 0, CONV_STATUS_RST, EXC_NONE);
    acc(1, NODE_ADDR_REG, 16'h0005, 0, EXC_NAK);
    acc(1, DELAYS_REG, 16'h0000, 0, EXC_NAK);
    acc(0, NODE_ADDR_REG, 0, NODE_ADDR_RST, EXC_NONE);
    nvWriteEnable = 1;
    acc(1, NODE_ADDR_REG, 16'h0000, 0, EXC_ILLEGAL_VALUE);
    acc(1, NODE_ADDR_REG, 16'h00E0, 0, EXC_ILLEGAL_VALUE);
    acc(1, NODE_ADDR_REG, 16'h00DF, 0, EXC_NONE);
    acc(0, NODE_ADDR_REG, 0, 16'h00DF, EXC_NONE);
    d = 16'(1 + $urandom % 223);
    acc(1, NODE_ADDR_REG, d, 0, EXC_NONE);
    acc(0, NODE_ADDR_REG, 0, d, EXC_NONE);
    chk({8'h00, nodeAddr}, {8'h00, d}, "node output");
    d = 16'($urandom);
    acc(1, SERIAL_SETUP_REG, d, 0, EXC_NONE);
    acc(0, SERIAL_SETUP_REG, 0, d, EXC_NONE);
    chk({8'h00, serialSetup}, {8'h00, d}, "setup output");
    acc(1, DELAYS_REG, 16'h3040, 0, EXC_ILLEGAL_VALUE);
    acc(1, DELAYS_REG, 16'h3103, 0, EXC_ILLEGAL_VALUE);
    acc(1, DELAYS_REG, 16'h303F, 0, EXC_NONE);
    acc(0, DELAYS_REG, 0, 16'h303F, EXC_NONE);
    acc(1, FW_VERSION_REG, 16'hFFFF, 0, EXC_ILLEGAL_ADDR);
    acc(1, CONV_STATUS_REG, 16'h0101, 0, EXC_ILLEGAL_ADDR);
    acc(0, FW_VERSION_REG, 0, FW, EXC_NONE);
    acc(0, 16'h9C50, 0, 0, EXC_ILLEGAL_ADDR);
    acc(1, DELAYS_REG, 16'h0201, 0, EXC_NONE);
    tick(2);
    // A gap shorter than the silence, or inside the query delay, restarts the wait
    frame(20);
    frame(SIL + 6);
    mask = 7'($urandom) | 7'h41;
    chanEnable = mask;
    slow = 1'($urandom);
    repeat (150) poll();
    slow = ~slow;
    repeat (150) poll();
    chanEnable = 0;
    tick(30);
    acc(0, CONV_STATUS_REG, 0, {5'h00, last, cnt}, EXC_NONE);
    tick(3);
    sys_rst = 1;
    tick(2);
    sys_rst = 0;
    acc(0, CONV_STATUS_REG, 0, 16'h0000, EXC_NONE);
    acc(0, NODE_ADDR_REG, 0, NODE_ADDR_RST, EXC_NONE);
    tick(3);
    chk(24'(expQ.size()), 24'h0, "pending answers");
    summarize();
  end
endmodule : test_mbim_setup_regs
